// *** src/mif_pkg.sv ***
// package of register map, field positions and reset values for the monitor/serial flag block
package mif_pkg;
    // =========================================================
    // register offsets (byte addresses)
    localparam logic [11:0] OFS_MON_FLAGS = 12'h008;
    localparam logic [11:0] OFS_SER1_FLAGS = 12'h00C;
    localparam logic [11:0] OFS_SER2_FLAGS = 12'h010;
    localparam logic [11:0] OFS_MON_TRIG = 12'h02C;
    localparam logic [11:0] OFS_MON_CLR = 12'h17C;
    localparam logic [11:0] OFS_SER1_CLR = 12'h190;
    localparam logic [11:0] OFS_SER2_CLR = 12'h194;
    localparam logic [11:0] OFS_IRQ_EN = 12'h1A0;
    // =========================================================
    // field layout
    localparam int MON_NUM = 5;
    localparam int MON_FLAG_W = 10;
    localparam int SER_FLAG_W = 3;
    localparam int SER_RX_BIT = 2;
    localparam int SER_TX_BIT = 1;
    localparam int SER_ERR_BIT = 0;
    localparam int IRQ_EN_MON_LSB = 0;
    localparam int IRQ_EN_SER1_LSB = 10;
    localparam int IRQ_EN_SER2_LSB = 13;
    localparam int IRQ_EN_W = 16;
    // =========================================================
    // trigger select codes
    localparam logic [1:0] TRIG_OFF = 2'h0;
    localparam logic [1:0] TRIG_RISE = 2'h1;
    localparam logic [1:0] TRIG_FALL = 2'h2;
    localparam logic [1:0] TRIG_BOTH = 2'h3;
    // =========================================================
    // reset values
    localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
    localparam logic [9:0] MON_TRIG_RST = 10'h030;
    localparam logic [15:0] IRQ_EN_RST = 16'h0000;
endpackage : mif_pkg

// *** src/mif_flags.sv ***
// sticky event flags for five monitor inputs and two serial channels
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - falling-edge flags for monitors five..one at bits 9,7,5,3,1
// - rising-edge flags for monitors five..one at bits 8,6,4,2,0
// - flags set only by hardware; flag registers are read-only
// - writing one to a clear bit clears the matching flag
// - writing zero to a clear bit leaves the flag unchanged
// - monitor clear register at 17C, bits 9..0 mirror the flags
// - flag one means event since last clear, zero means none
// - channel one receive flag at bit 2
// - channel one transmit flag at bit 1
// - channel one error flag at bit 0
// - channel two flags in own register: receive 2, transmit 1, error 0
// - channel one flags at 00C, clear at 190
// - channel two flags at 010, clear at 194
// - reserved bits read zero; software writes zero there
// - all flag and clear registers reset to zero
// - per-monitor trigger select: off, rising, falling, both
// - hardware set wins over a same-cycle software clear
module mif_flags (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // monitor input levels, bit 0 is input one
    input wire logic [mif_pkg::MON_NUM-1:0] hv_monitor_in,
    // serial channel event pulses
    input wire logic ch1_receive_evt,
    input wire logic ch1_transmit_evt,
    input wire logic ch1_error_evt,
    input wire logic ch2_receive_evt,
    input wire logic ch2_transmit_evt,
    input wire logic ch2_error_evt,
    // interrupt
    output logic irq
);

    // =========================================================
    // storage
    logic [mif_pkg::MON_FLAG_W-1:0] mon_flags_r;
    logic [mif_pkg::SER_FLAG_W-1:0] ser1_flags_r;
    logic [mif_pkg::SER_FLAG_W-1:0] ser2_flags_r;
    logic [2*mif_pkg::MON_NUM-1:0] mon_trig_r;
    logic [mif_pkg::IRQ_EN_W-1:0] irq_en_r;
    logic [mif_pkg::MON_NUM-1:0] mon_prev_r;
    logic mon_prev_valid_r;
    logic [31:0] reg_rdata_r;

    logic [mif_pkg::MON_FLAG_W-1:0] mon_set;
    logic [mif_pkg::MON_FLAG_W-1:0] mon_clr;
    logic [mif_pkg::SER_FLAG_W-1:0] ser1_set;
    logic [mif_pkg::SER_FLAG_W-1:0] ser2_set;
    logic [mif_pkg::SER_FLAG_W-1:0] ser1_clr;
    logic [mif_pkg::SER_FLAG_W-1:0] ser2_clr;

    // register port write decode
    logic wr_mon_clr;
    logic wr_ser1_clr;
    logic wr_ser2_clr;
    logic wr_mon_trig;
    logic wr_irq_en;

    // zero-extended read views
    logic [31:0] mon_flags_view;
    logic [31:0] ser1_flags_view;
    logic [31:0] ser2_flags_view;
    logic [31:0] mon_trig_view;
    logic [31:0] irq_en_view;

    // per-source interrupt requests
    logic [mif_pkg::MON_FLAG_W-1:0] mon_irq_req;
    logic [mif_pkg::SER_FLAG_W-1:0] ser1_irq_req;
    logic [mif_pkg::SER_FLAG_W-1:0] ser2_irq_req;
    logic mon_irq_any;
    logic ser1_irq_any;
    logic ser2_irq_any;

    // =========================================================
    // monitor edge detection
    // last sampled level of every monitor input
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mon_prev_r <= '0;
        end else begin
            mon_prev_r <= hv_monitor_in;
        end
    end

    // armed one edge after reset, so a high input at release is no edge
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mon_prev_valid_r <= 1'b0;
        end else begin
            mon_prev_valid_r <= 1'b1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < mif_pkg::MON_NUM; gi++) begin : g_mon
            logic [1:0] trig;
            logic level_now;
            logic level_old;
            logic rise;
            logic fall;
            logic rise_en;
            logic fall_en;
            assign trig = mon_trig_r[2*gi+1:2*gi];
            assign level_now = hv_monitor_in[gi];
            assign level_old = mon_prev_r[gi];
            assign rise = mon_prev_valid_r && level_now && !level_old;
            assign fall = mon_prev_valid_r && !level_now && level_old;
            always_comb begin
                rise_en = 1'b0;
                fall_en = 1'b0;
                case (trig)
                    mif_pkg::TRIG_OFF: begin
                        rise_en = 1'b0;
                        fall_en = 1'b0;
                    end
                    mif_pkg::TRIG_RISE: begin
                        rise_en = 1'b1;
                        fall_en = 1'b0;
                    end
                    mif_pkg::TRIG_FALL: begin
                        rise_en = 1'b0;
                        fall_en = 1'b1;
                    end
                    mif_pkg::TRIG_BOTH: begin
                        rise_en = 1'b1;
                        fall_en = 1'b1;
                    end
                    default: begin
                        rise_en = 1'b0;
                        fall_en = 1'b0;
                    end
                endcase
            end
            assign mon_set[2*gi] = rise && rise_en;
            assign mon_set[2*gi+1] = fall && fall_en;
        end
    endgenerate

    assign ser1_set[mif_pkg::SER_RX_BIT] = ch1_receive_evt;
    assign ser1_set[mif_pkg::SER_TX_BIT] = ch1_transmit_evt;
    assign ser1_set[mif_pkg::SER_ERR_BIT] = ch1_error_evt;
    assign ser2_set[mif_pkg::SER_RX_BIT] = ch2_receive_evt;
    assign ser2_set[mif_pkg::SER_TX_BIT] = ch2_transmit_evt;
    assign ser2_set[mif_pkg::SER_ERR_BIT] = ch2_error_evt;

    // =========================================================
    // register port write decode
    // monitor clear decode
    assign wr_mon_clr = reg_wr && (reg_addr == mif_pkg::OFS_MON_CLR);
    assign wr_ser1_clr = reg_wr && (reg_addr == mif_pkg::OFS_SER1_CLR);
    assign wr_ser2_clr = reg_wr && (reg_addr == mif_pkg::OFS_SER2_CLR);
    assign wr_mon_trig = reg_wr && (reg_addr == mif_pkg::OFS_MON_TRIG);
    assign wr_irq_en = reg_wr && (reg_addr == mif_pkg::OFS_IRQ_EN);

    // =========================================================
    // clear pulses, no state kept
    // write-only pulses
    assign mon_clr = wr_mon_clr ? reg_wdata[mif_pkg::MON_FLAG_W-1:0] : '0;
    assign ser1_clr = wr_ser1_clr ? reg_wdata[mif_pkg::SER_FLAG_W-1:0] : '0;
    assign ser2_clr = wr_ser2_clr ? reg_wdata[mif_pkg::SER_FLAG_W-1:0] : '0;

    // =========================================================
    // sticky flags, set term applied after the clear so the event wins
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mon_flags_r <= '0;
        end else begin
            mon_flags_r <= (mon_flags_r & ~mon_clr) | mon_set;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ser1_flags_r <= '0;
        end else begin
            ser1_flags_r <= (ser1_flags_r & ~ser1_clr) | ser1_set;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ser2_flags_r <= '0;
        end else begin
            ser2_flags_r <= (ser2_flags_r & ~ser2_clr) | ser2_set;
        end
    end

    // =========================================================
    // control registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mon_trig_r <= mif_pkg::MON_TRIG_RST;
        end else if (wr_mon_trig) begin
            mon_trig_r <= reg_wdata[2*mif_pkg::MON_NUM-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irq_en_r <= mif_pkg::IRQ_EN_RST;
        end else if (wr_irq_en) begin
            irq_en_r <= reg_wdata[mif_pkg::IRQ_EN_W-1:0];
        end
    end

    // =========================================================
    // read path, data one cycle after the strobe
    // reserved bits are zero in every view
    assign mon_flags_view = {{(32-mif_pkg::MON_FLAG_W){1'b0}}, mon_flags_r};
    assign ser1_flags_view = {{(32-mif_pkg::SER_FLAG_W){1'b0}}, ser1_flags_r};
    assign ser2_flags_view = {{(32-mif_pkg::SER_FLAG_W){1'b0}}, ser2_flags_r};
    assign mon_trig_view = {{(32-2*mif_pkg::MON_NUM){1'b0}}, mon_trig_r};
    assign irq_en_view = {{(32-mif_pkg::IRQ_EN_W){1'b0}}, irq_en_r};

    // the word drops to zero outside a read, so no stale value lingers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_r <= mif_pkg::FLAGS_RST;
        end else if (reg_rd) begin
            case (reg_addr)
                mif_pkg::OFS_MON_FLAGS: reg_rdata_r <= mon_flags_view;
                mif_pkg::OFS_SER1_FLAGS: reg_rdata_r <= ser1_flags_view;
                mif_pkg::OFS_SER2_FLAGS: reg_rdata_r <= ser2_flags_view;
                mif_pkg::OFS_MON_TRIG: reg_rdata_r <= mon_trig_view;
                mif_pkg::OFS_IRQ_EN: reg_rdata_r <= irq_en_view;
                default: reg_rdata_r <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_r <= 32'h0000_0000;
        end
    end

    assign reg_rdata = reg_rdata_r;

    // =========================================================
    // interrupt output
    // each source is masked by its own slice of the enable register
    assign mon_irq_req = mon_flags_r
        & irq_en_r[mif_pkg::IRQ_EN_MON_LSB +: mif_pkg::MON_FLAG_W];
    assign ser1_irq_req = ser1_flags_r
        & irq_en_r[mif_pkg::IRQ_EN_SER1_LSB +: mif_pkg::SER_FLAG_W];
    assign ser2_irq_req = ser2_flags_r
        & irq_en_r[mif_pkg::IRQ_EN_SER2_LSB +: mif_pkg::SER_FLAG_W];

    assign mon_irq_any = |mon_irq_req;
    assign ser1_irq_any = |ser1_irq_req;
    assign ser2_irq_any = |ser2_irq_req;

    // level while an enabled flag is set
    assign irq = mon_irq_any || ser1_irq_any || ser2_irq_any;

endmodule : mif_flags

`default_nettype wire

// *** verif/mif_flags_asserts.sv ***
// port checks for the monitor and serial event flag block
`timescale 1ns/1ps
`default_nettype none
module mif_flags_asserts (
    // watched ports
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic ch1_receive_evt,
    input wire logic ch2_error_evt,
    input wire logic irq
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    // =========================================================
    // assertions
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data not zero when idle");
    AST_CLR_RD0: assert property (reg_rd && reg_addr inside {12'h17C, 12'h190, 12'h194}
        |=> reg_rdata == 32'h0) else $error("clear register read not zero");
    AST_MON_RSV: assert property (reg_rd && reg_addr == mif_pkg::OFS_MON_FLAGS
        |=> reg_rdata[31:10] == 22'h0) else $error("monitor reserved bits set");
    AST_SER_RSV: assert property (reg_rd && reg_addr == mif_pkg::OFS_SER2_FLAGS
        |=> reg_rdata[31:3] == 29'h0) else $error("serial reserved bits set");
    AST_RX1_SET: assert property (ch1_receive_evt ##1 !reg_wr ##1
        reg_rd && reg_addr == mif_pkg::OFS_SER1_FLAGS |=> reg_rdata[2])
        else $error("receive flag one not set");
    AST_ER2_SET: assert property (ch2_error_evt ##1 !reg_wr [*3] ##1
        reg_rd && reg_addr == mif_pkg::OFS_SER2_FLAGS |=> reg_rdata[0])
        else $error("error flag two not set");
    AST_CLR_WORKS: assert property (reg_wr && reg_addr == mif_pkg::OFS_SER1_CLR
        && reg_wdata[2] && !ch1_receive_evt ##1 !ch1_receive_evt [*4] ##0
        reg_rd && reg_addr == mif_pkg::OFS_SER1_FLAGS |=> !reg_rdata[2])
        else $error("receive flag one not cleared");
    AST_IRQ_RST: assert property ($rose(rst_b) |-> !irq)
        else $error("interrupt high after reset");
    COV_SET_CLR: cover property (ch1_receive_evt && reg_wr);
    COV_IRQ_UP: cover property ($rose(irq));
    COV_IRQ_DN: cover property ($fell(irq));
endmodule : mif_flags_asserts
bind mif_flags mif_flags_asserts u_asserts (.clk_sys(clk_sys), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ch1_receive_evt(ch1_receive_evt),
    .ch2_error_evt(ch2_error_evt), .irq(irq));
`default_nettype wire

// *** verif/mif_flags_bench.sv ***
// self-checking bench for the monitor and serial event flag block
`timescale 1ns/1ps
`default_nettype none
module mif_flags_bench;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0, irq;
    logic [4:0] hv = 5'h00;
    logic [5:0] ev = 6'h00;
    int n_fail = 0, tests_run = 0;
    // rows: events {ch1 rx,tx,err, ch2 rx,tx,err}, then ch1 flags, then ch2 flags
    logic [11:0] rows [4] = '{12'h861, 12'h492, 12'h30C, 12'hFFF};
    always #10 clk_sys = ~clk_sys;
    mif_flags u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .hv_monitor_in(hv), .ch1_receive_evt(ev[5]), .ch1_transmit_evt(ev[4]),
        .ch1_error_evt(ev[3]), .ch2_receive_evt(ev[2]), .ch2_transmit_evt(ev[1]),
        .ch2_error_evt(ev[0]), .irq(irq));
    // =========================================================
    // tasks
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk("rdata", e, reg_rdata);
        @(posedge clk_sys);
    endtask : rd
    task automatic irq_is(input logic e);
        @(negedge clk_sys);
        chk("irq", {31'h0, e}, {31'h0, irq});
        @(posedge clk_sys);
    endtask : irq_is
    task automatic pulse(input logic [5:0] e, input logic [4:0] h);
        ev <= e;
        hv <= h;
        @(posedge clk_sys);
        ev <= 6'h00;
        @(posedge clk_sys);
    endtask : pulse
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    // =========================================================
    // main sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        rd(mif_pkg::OFS_MON_FLAGS, 32'h0);
        rd(mif_pkg::OFS_MON_TRIG, 32'h30);
        foreach (rows[i]) begin
            pulse(rows[i][11:6], 5'h00);
            rd(mif_pkg::OFS_SER1_FLAGS, {29'h0, rows[i][5:3]});
            rd(mif_pkg::OFS_SER2_FLAGS, {29'h0, rows[i][2:0]});
            wr(mif_pkg::OFS_SER1_CLR, 32'h7);
            wr(mif_pkg::OFS_SER2_CLR, 32'h7);
            rd(mif_pkg::OFS_SER1_FLAGS, 32'h0);
            rd(mif_pkg::OFS_SER2_FLAGS, 32'h0);
        end
        for (int c = 0; c < 4; c++) begin
            wr(mif_pkg::OFS_MON_TRIG, 32'(c));
            pulse(6'h00, 5'h01);
            pulse(6'h00, 5'h00);
            rd(mif_pkg::OFS_MON_FLAGS, 32'(c));
            wr(mif_pkg::OFS_MON_CLR, 32'h3FF);
        end
        wr(mif_pkg::OFS_MON_TRIG, 32'h3FF);
        pulse(6'h00, 5'h1F);
        rd(mif_pkg::OFS_MON_FLAGS, 32'h155);
        pulse(6'h00, 5'h00);
        wr(mif_pkg::OFS_MON_CLR, 32'h155);
        rd(mif_pkg::OFS_MON_FLAGS, 32'h2AA);
        rd(mif_pkg::OFS_MON_CLR, 32'h0);
        wr(mif_pkg::OFS_IRQ_EN, 32'h2);
        irq_is(1'b1);
        wr(mif_pkg::OFS_MON_CLR, 32'h2);
        irq_is(1'b0);
        wr(mif_pkg::OFS_IRQ_EN, 32'h0000_2000);
        irq_is(1'b0);
        pulse(6'h01, 5'h00);
        irq_is(1'b1);
        wr(mif_pkg::OFS_SER2_CLR, 32'h1);
        irq_is(1'b0);
        wr(mif_pkg::OFS_SER1_FLAGS, 32'h7);
        rd(mif_pkg::OFS_SER1_FLAGS, 32'h0);
        rd(12'h100, 32'h0);
        // event and clear land on the same edge
        ev <= 6'h20;
        reg_addr <= mif_pkg::OFS_SER1_CLR;
        reg_wdata <= 32'h4;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        ev <= 6'h00;
        reg_wr <= 1'b0;
        @(posedge clk_sys);
        rd(mif_pkg::OFS_SER1_FLAGS, 32'h4);
        rst_b <= 1'b0;
        @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        rd(mif_pkg::OFS_MON_FLAGS, 32'h0);
        rd(mif_pkg::OFS_SER1_FLAGS, 32'h0);
        final_report();
    end
    initial begin
        repeat (2000) @(posedge clk_sys);
        n_fail++;
        final_report();
    end
endmodule : mif_flags_bench
`default_nettype wire
